/* core/psw_core.sv */
// Processor status word with event entry and return, mask handling,
// per-context saved status and return address, and register bank select.
// Assumes the pipeline presents at most one entry or return per cycle and
// that every strobe is a one-cycle pulse synchronous to clk.
// Contract
// RL1 - Mode bits encode NMI, exception, levels 3..0, supervisor, application
// RL2 - Reset leaves the mode bits at supervisor
// RL3 - Mode changes only by event entry, system call or returns
// RL4 - Exception mask blocks exceptions; set at reset, exception, debug entry
// RL5 - Level 3 taken only with its mask and global mask clear
// RL6 - Level 2 mask set on level 3 or 2 entry, clear at reset
// RL7 - Level 1 mask set on level 3, 2 or 1 entry
// RL8 - Level 0 mask set on any interrupt entry, clear at reset
// RL9 - Global mask blocks every level and is set after reset
// RL10 - Global mask set on exception, debug, bytecode trap; cleared on return
// RL11 - Debug mask prevents debug entry; cleared at reset; software writable
// RL12 - Debug state bit changes only by debug hardware or its instructions
// RL13 - Bytecode state bit selects bytecode decoding; cleared at reset
// RL14 - Remap bit makes the register file act as a stack
// RL15 - Scratch bit free for software, cleared after reset
// RL16 - Lock flag for conditional store, cleared by reset and exception return
// RL17 - Saturation flag is sticky until the clear-flag instruction
// RL18 - Condition flags follow arithmetic and logic results
// RL19 - Low halfword holds flags, high halfword holds mode and state
// RL20 - Level 3 uses own R8..R10; stack pointer split application/system
// RL21 - Each non-application context saves its own status and return address
// RL22 - Software reaches the word only by privileged move instructions
// RL23 - Simultaneous mask-setting events apply together with the mode change
// RL24 - Field positions are fixed before implementation
`timescale 1ns/100ps
module psw_core
    import psw_pkg::*;
#(
    parameter int DW = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic evEnter,
    input wire logic [2:0] evMode,
    input wire logic [31:0] evPc,
    input wire logic evReturn,
    input wire logic retIsExc,
    input wire logic dbgEnter,
    input wire logic dbgReturn,
    input wire logic bcTrap,
    input wire logic bcTrapRet,
    input wire logic bcEnter,
    input wire logic bcLeave,
    input wire logic remapSet,
    input wire logic remapClr,
    input wire logic lockWe,
    input wire logic lockVal,
    input wire flag_upd_s flagUpd,
    input wire logic satClr,
    input wire logic sysWr,
    input wire logic sysRd,
    input wire logic [7:0] sysIdx,
    input wire logic [31:0] sysWdata,
    output logic [31:0] psw_r,
    output logic [31:0] sysRdata_r,
    output logic [31:0] retPc_r,
    output logic retPcValid_r,
    output logic [3:0] irqEnable_r,
    output logic excEnable_r,
    output logic dbgEnable_r,
    output logic shadowHigh_r,
    output logic sysStack_r
);
    // Elaboration check: the field map only fits a 32-bit word
    if (DW != W) begin : gBadWidth
        $error("psw_core serves a 32-bit word only");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end
    wire logic rstN = rstSync_r;

    ////////////////////////////////////////////////////////////////////////
    // Saved status and return address, one slot per context
    logic [31:0] savedSt_r [NCTX];
    logic [31:0] savedPc_r [NCTX];
    mode_e curMode;
    assign curMode = mode_e'(psw_r[B_M0 +: MODE_W]); // [RL1] [RL24]
    wire logic dbgOk = !psw_r[B_DM] && !psw_r[B_D];
    wire logic dbgGo = dbgEnter && dbgOk; // [RL11]
    wire logic enterGo = evEnter && !dbgGo;
    wire logic retGo = evReturn && curMode != MODE_APP;
    wire logic dRetGo = dbgReturn && psw_r[B_D];
    wire logic [2:0] retSlot = dRetGo ? DBG_SLOT : curMode;
    wire logic [4:0] rsIdx = 5'(sysIdx - RSR_SUP_IDX);
    wire logic [4:0] raIdx = 5'(sysIdx - RAR_SUP_IDX);
    wire logic rsHit = sysIdx >= RSR_SUP_IDX && sysIdx <= RSR_DBG_IDX;
    wire logic raHit = sysIdx >= RAR_SUP_IDX && sysIdx <= RAR_DBG_IDX;

    // Supervisor save sits at index 0 of the map; slot follows mode code
    function automatic logic [2:0] mapSlot(input logic [4:0] i);
        return (i == 5'h07) ? DBG_SLOT : 3'(i + 5'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next status word; later steps win, so events override a same-cycle
    // software write and every mask lands with the mode in one edge
    logic [31:0] psw_nxt;
    always_comb begin
        psw_nxt = psw_r;
        if (sysWr && sysIdx == SR_IDX) begin // [RL22]
            // Mode, debug state, bytecode and remap ignore software
            psw_nxt = (psw_r & ~SW_MASK)
                | (sysWdata & SW_MASK); // [RL3] [RL12] [RL15]
        end
        if (flagUpd.we) begin // [RL18]
            psw_nxt[B_V] = flagUpd.v;
            psw_nxt[B_N] = flagUpd.n;
            psw_nxt[B_Z] = flagUpd.z;
            psw_nxt[B_C] = flagUpd.c;
        end
        if (satClr) psw_nxt[B_Q] = 1'b0;
        if (flagUpd.satOvf) psw_nxt[B_Q] = 1'b1; // Set beats clear [RL17]
        if (lockWe) psw_nxt[B_L] = lockVal; // [RL16]
        if (bcEnter) psw_nxt[B_J] = 1'b1; // [RL13]
        if (bcLeave) psw_nxt[B_J] = 1'b0;
        if (remapSet) psw_nxt[B_R] = 1'b1; // [RL14]
        if (remapClr) psw_nxt[B_R] = 1'b0;
        if (bcTrapRet) psw_nxt[B_GM] = 1'b0; // [RL10]
        if (bcTrap) psw_nxt[B_GM] = 1'b1; // [RL10]
        if (retGo || dRetGo) begin
            psw_nxt = savedSt_r[retSlot]; // [RL3] [RL21]
            if (retIsExc && !dRetGo) psw_nxt[B_L] = 1'b0; // [RL16]
        end
        if (enterGo) begin
            psw_nxt[B_M0 +: MODE_W] = evMode; // [RL1] [RL3] [RL23]
            case (mode_e'(evMode))
                MODE_EXC: begin
                    psw_nxt[B_EM] = 1'b1; // [RL4]
                    psw_nxt[B_GM] = 1'b1; // [RL10]
                end
                MODE_INT3: psw_nxt[B_I0M +: 4] = 4'hF; // [RL5] [RL6]
                MODE_INT2: psw_nxt[B_I0M +: 3] = 3'h7; // [RL6] [RL7]
                MODE_INT1: psw_nxt[B_I0M +: 2] = 2'h3; // [RL7] [RL8]
                MODE_INT0: psw_nxt[B_I0M] = 1'b1; // [RL8]
                default: ;
            endcase
        end
        if (dbgGo) begin
            psw_nxt[B_D] = 1'b1; // [RL12]
            psw_nxt[B_EM] = 1'b1; // [RL4]
            psw_nxt[B_GM] = 1'b1; // [RL10]
        end
    end

    // Status word register; reset enters supervisor with EM and GM set
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) psw_r <= PSW_RST; // [RL2] [RL4] [RL9] [RL19]
        else psw_r <= psw_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Context save on entry, software access by move-to
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < NCTX; i++) begin
                savedSt_r[i] <= 32'h0000_0000;
                savedPc_r[i] <= 32'h0000_0000;
            end
        end else if (dbgGo) begin
            savedSt_r[DBG_SLOT] <= psw_r; // [RL21]
            savedPc_r[DBG_SLOT] <= evPc;
        end else if (enterGo && evMode != MODE_APP) begin
            savedSt_r[evMode] <= psw_r; // [RL21]
            savedPc_r[evMode] <= evPc;
        end else if (sysWr && rsHit) begin
            savedSt_r[mapSlot(rsIdx)] <= sysWdata;
        end else if (sysWr && raHit) begin
            savedPc_r[mapSlot(raIdx)] <= sysWdata;
        end
    end

    // Return address handed back to fetch on a return
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            retPc_r <= 32'h0000_0000;
            retPcValid_r <= 1'b0;
        end else begin
            retPcValid_r <= (retGo || dRetGo) && !enterGo && !dbgGo;
            if (retGo || dRetGo) retPc_r <= savedPc_r[retSlot]; // [RL21]
        end
    end

    // Move-from read data, one cycle after the request; unmapped reads zero
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) sysRdata_r <= 32'h0000_0000;
        else if (sysRd) begin
            if (sysIdx == SR_IDX) sysRdata_r <= psw_r; // [RL22]
            else if (rsHit) sysRdata_r <= savedSt_r[mapSlot(rsIdx)];
            else if (raHit) sysRdata_r <= savedPc_r[mapSlot(raIdx)];
            else sysRdata_r <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acceptance and bank select, computed from the next word so they
    // track the status register without an extra cycle of lag
    wire logic [2:0] nxtMode = psw_nxt[B_M0 +: MODE_W];
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqEnable_r <= 4'h0;
            excEnable_r <= 1'b0;
            dbgEnable_r <= 1'b1;
            shadowHigh_r <= 1'b0;
            sysStack_r <= 1'b1;
        end else begin
            for (int l = 0; l < 4; l++) begin
                irqEnable_r[l] <= !psw_nxt[B_GM]
                    && !psw_nxt[B_I0M+l]; // [RL5] [RL8] [RL9]
            end
            excEnable_r <= !psw_nxt[B_EM]; // [RL4]
            dbgEnable_r <= !psw_nxt[B_DM] && !psw_nxt[B_D]; // [RL11]
            shadowHigh_r <= nxtMode == MODE_INT3; // [RL20]
            sysStack_r <= nxtMode != MODE_APP; // [RL20]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence int3Entry;
        enterGo && evMode == MODE_INT3;
    endsequence
    sequence excEntry;
        enterGo && evMode == MODE_EXC;
    endsequence

    reset_mode_a: assert property (@(posedge clk) $rose(rstN) |-> // [RL2]
        psw_r[B_M0 +: MODE_W] == MODE_SUP && psw_r[B_GM] && psw_r[B_EM])
        else $error("reset mode or masks wrong");
    int3_masks_a: assert property (@(posedge clk) disable iff (!rstN)
        int3Entry |=> psw_r[B_I0M +: 4] == 4'hF && !irqEnable_r[3]) // [RL5]
        else $error("level 3 entry masks wrong");
    int1_masks_a: assert property (@(posedge clk) disable iff (!rstN)
        enterGo && evMode == MODE_INT1 |=> // [RL7]
        psw_r[B_I0M +: 2] == 2'h3 && psw_r[B_M0 +: MODE_W] == MODE_INT1)
        else $error("level 1 entry masks wrong");
    exc_masks_a: assert property (@(posedge clk) disable iff (!rstN)
        excEntry |=> psw_r[B_EM] && psw_r[B_GM] && !excEnable_r) // [RL4]
        else $error("exception entry masks wrong");
    global_block_a: assert property (@(posedge clk) disable iff (!rstN)
        psw_r[B_GM] && !$past(psw_r[B_GM]) |-> irqEnable_r == 4'h0) // [RL9]
        else $error("interrupt enabled under global mask");
    mode_stable_a: assert property (@(posedge clk) disable iff (!rstN)
        !enterGo && !retGo && !dRetGo |=>
        $stable(psw_r[B_M0 +: MODE_W])) // [RL3]
        else $error("mode changed without event");
    debug_block_a: assert property (@(posedge clk) disable iff (!rstN)
        dbgEnter && psw_r[B_DM] && !psw_r[B_D] |=> !psw_r[B_D]) // [RL11]
        else $error("debug entered while masked");
    sat_sticky_a: assert property (@(posedge clk) disable iff (!rstN)
        psw_r[B_Q] && !satClr && !retGo && !dRetGo && !sysWr |=>
        psw_r[B_Q]) // [RL17]
        else $error("saturation flag dropped");
    lock_rete_a: assert property (@(posedge clk) disable iff (!rstN)
        retGo && retIsExc && !enterGo && !dbgGo |=> !psw_r[B_L]) // [RL16]
        else $error("lock survived exception return");
    shadow_sel_a: assert property (@(posedge clk) disable iff (!rstN)
        int3Entry |=> shadowHigh_r && sysStack_r) // [RL20]
        else $error("level 3 bank not selected");
    save_ctx_a: assert property (@(posedge clk) disable iff (!rstN)
        int3Entry |=> savedSt_r[MODE_INT3] == $past(psw_r)) // [RL21]
        else $error("status not saved on entry");
    trap_gm_a: assert property (@(posedge clk) disable iff (!rstN)
        bcTrap |=> psw_r[B_GM]) // [RL10]
        else $error("bytecode trap left global mask clear");
endmodule

/* shared/psw_pkg.sv */
// Package for the processor status word block: field positions, reset
// value, mode codes, system register indexes and the flag update carrier.
// Assumes a 32-bit status word and a three-bit execution mode.
package psw_pkg;
    localparam int W = 32;
    // Low halfword: condition flags and the lock, scratch and remap bits
    localparam int B_C = 0;
    localparam int B_Z = 1;
    localparam int B_N = 2;
    localparam int B_V = 3;
    localparam int B_Q = 4;
    localparam int B_L = 5;
    localparam int B_T = 14;
    localparam int B_R = 15;
    // High halfword: masks, mode and state
    localparam int B_GM = 16;
    localparam int B_I0M = 17;
    localparam int B_EM = 21;
    localparam int B_M0 = 22;
    localparam int B_D = 26;
    localparam int B_DM = 27;
    localparam int B_J = 28;
    localparam int B_H = 29;
    localparam int MODE_W = 3;
    localparam int NCTX = 8;
    // Supervisor mode, exception mask and global mask set at reset
    localparam logic [31:0] PSW_RST = 32'h0060_0000 | 32'h0001_0000;
    // Fields software may write with a move-to; mode and state excluded
    localparam logic [31:0] SW_MASK = 32'h283F_403F;
    // System register indexes
    localparam logic [7:0] SR_IDX = 8'h00;
    localparam logic [7:0] RSR_SUP_IDX = 8'h05;
    localparam logic [7:0] RSR_DBG_IDX = 8'h0C;
    localparam logic [7:0] RAR_SUP_IDX = 8'h0D;
    localparam logic [7:0] RAR_DBG_IDX = 8'h14;
    // Context slot 0 holds the debug save, slots 1..7 follow the mode code
    localparam logic [2:0] DBG_SLOT = 3'h0;

    typedef enum logic [2:0] {
        MODE_APP = 3'b000,
        MODE_SUP = 3'b001,
        MODE_INT0 = 3'b010,
        MODE_INT1 = 3'b011,
        MODE_INT2 = 3'b100,
        MODE_INT3 = 3'b101,
        MODE_EXC = 3'b110,
        MODE_NMI = 3'b111
    } mode_e;

    typedef struct packed {
        logic we;
        logic v;
        logic n;
        logic z;
        logic c;
        logic satOvf;
    } flag_upd_s;
endpackage

/* test/psw_pipe_model.sv */
// Pipeline and event logic model that drives the status word strobes.
// Assumes one request per call, launched and released on rising edges.
`timescale 1ns/100ps
module psw_pipe_model
    import psw_pkg::*;
(
    input wire logic clk,
    output logic [15:0] req,
    output logic [2:0] evMode,
    output logic [7:0] sysIdx,
    output logic [31:0] val,
    output flag_upd_s flagUpd
);
    // Idle levels before the first request
    initial begin
        req = 16'h0000;
        evMode = 3'h0;
        sysIdx = 8'h00;
        val = 32'h0000_0000;
        flagUpd = 6'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Request held for one taking edge; released qualifiers are inverted
    // so that a stale value can never pass for fresh data
    task automatic issue(input logic [15:0] s, input logic [2:0] m,
        input logic [7:0] x, input logic [31:0] v, input flag_upd_s f);
        @(posedge clk);
        req <= s;
        evMode <= m;
        sysIdx <= x;
        val <= v;
        flagUpd <= f;
        @(posedge clk);
        req <= 16'h0000;
        evMode <= ~m;
        sysIdx <= ~x;
        val <= ~v;
        flagUpd <= 6'h00;
    endtask
endmodule

/* test/test_psw_core.sv */
// Self-checking bench for the processor status word block.
// Assumes the pipeline model drives every strobe; checks run one step
// after the edge that takes each request.
`timescale 1ns/100ps
module test_psw_core;
    import psw_pkg::*;
    localparam logic [15:0] ENT = 16'h0001, RET = 16'h0002, DBG = 16'h0004;
    localparam logic [15:0] DRET = 16'h0008, LOCK = 16'h0400;
    localparam logic [15:0] SCLR = 16'h0800, WR = 16'h1000, RD = 16'h2000;
    localparam logic [15:0] REXC = 16'h4000, LVAL = 16'h8000;
    localparam flag_upd_s F0 = 6'h00;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] req;
    logic [2:0] evMode;
    logic [7:0] sysIdx;
    logic [31:0] val, psw_r, sysRdata_r, retPc_r, base, exp;
    flag_upd_s flagUpd;
    logic [3:0] irqEnable_r;
    logic retPcValid_r, excEnable_r, dbgEnable_r, shadowHigh_r, sysStack_r;
    logic [31:0] tabB [3] = '{32'h0001_0000, 32'h1000_0000, 32'h0000_8000};
    int error_cnt = 0;
    int total_checks = 0;

    // 250 MHz core clock
    always #2 clk = ~clk;

    psw_pipe_model pm (.clk(clk), .req(req), .evMode(evMode),
        .sysIdx(sysIdx), .val(val), .flagUpd(flagUpd));
    psw_core #(.DW(32)) uut (.clk(clk), .reset_n(reset_n),
        .evEnter(req[0]), .evMode(evMode), .evPc(val), .evReturn(req[1]),
        .retIsExc(req[14]), .dbgEnter(req[2]), .dbgReturn(req[3]),
        .bcTrap(req[4]), .bcTrapRet(req[5]), .bcEnter(req[6]),
        .bcLeave(req[7]), .remapSet(req[8]), .remapClr(req[9]),
        .lockWe(req[10]), .lockVal(req[15]), .flagUpd(flagUpd),
        .satClr(req[11]), .sysWr(req[12]), .sysRd(req[13]),
        .sysIdx(sysIdx), .sysWdata(val), .psw_r(psw_r),
        .sysRdata_r(sysRdata_r), .retPc_r(retPc_r),
        .retPcValid_r(retPcValid_r), .irqEnable_r(irqEnable_r),
        .excEnable_r(excEnable_r), .dbgEnable_r(dbgEnable_r),
        .shadowHigh_r(shadowHigh_r), .sysStack_r(sysStack_r));
    ////////////////////////////////////////////////////////////////////////
    // Comparison, request and verdict helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic go(input logic [15:0] s, input logic [2:0] m,
        input logic [7:0] x, input logic [31:0] v, input flag_upd_s f);
        pm.issue(s, m, x, v, f);
        #1;
    endtask
    function automatic logic [3:0] ien(input logic [31:0] p);
        for (int k = 0; k < 4; k++) begin
            ien[k] = !p[B_GM] && !p[B_I0M + k];
        end
    endfunction
    // Word and the enables derived from it, all from the expected word
    task automatic st(input logic [31:0] e);
        chk(psw_r, e);
        chk({irqEnable_r, excEnable_r, dbgEnable_r},
            {ien(e), !e[B_EM], !(e[B_DM] | e[B_D])});
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        for (int i = 0; i < 20000; i++) begin
            @(posedge clk);
        end
        error_cnt++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        st(PSW_RST);
        chk({shadowHigh_r, sysStack_r}, 32'h1);
        go(RD, 3'h0, SR_IDX, 32'h0, F0);
        chk(sysRdata_r, PSW_RST);
        go(WR, 3'h0, SR_IDX, 32'hFFFF_FFFF, F0);
        st(PSW_RST | SW_MASK);
        base = PSW_RST & ~SW_MASK;
        go(WR, 3'h0, SR_IDX, base, F0);
        st(base);
        // Every mode code except application entered, saved context read back, then returned
        for (int c = 1; c < 8; c++) begin
            exp = base;
            exp[B_M0 +: 3] = c[2:0];
            if (c >= 2 && c <= 5) begin
                exp[B_I0M +: 4] = 4'hF >> (5 - c);
            end
            if (c == 6) begin
                exp[B_EM] = 1'b1;
                exp[B_GM] = 1'b1;
            end
            go(ENT, c[2:0], 8'h00, 32'hA000_0000 + c, F0);
            st(exp);
            chk({shadowHigh_r, sysStack_r}, {c == 5, 1'b1});
            go(RD, 3'h0, RSR_SUP_IDX + 8'(c - 1), 32'h0, F0);
            chk(sysRdata_r, base);
            go(RD, 3'h0, RAR_SUP_IDX + 8'(c - 1), 32'h0, F0);
            chk(sysRdata_r, 32'hA000_0000 + c);
            go(RET, 3'h0, 8'h00, 32'h0, F0);
            st(base);
            chk(retPc_r, 32'hA000_0000 + c);
            chk(retPcValid_r, 32'h1);
        end
        // Level 2 entry and bytecode trap in the same cycle
        exp = base;
        exp[B_M0 +: 3] = MODE_INT2;
        exp[B_I0M +: 3] = 3'h7;
        exp[B_GM] = 1'b1;
        go(ENT | 16'h0010, MODE_INT2, 8'h00, 32'h0, F0);
        st(exp);
        go(RET, 3'h0, 8'h00, 32'h0, F0);
        st(base);
        // Debug entry refused while blocked, then taken and left
        go(WR, 3'h0, SR_IDX, base | 32'h0800_0000, F0);
        go(DBG, 3'h0, 8'h00, 32'h0000_0BAD, F0);
        st(base | 32'h0800_0000);
        go(WR, 3'h0, SR_IDX, base, F0);
        go(DBG, 3'h0, 8'h00, 32'h0000_0D06, F0);
        chk(psw_r & 32'h0421_0000, 32'h0421_0000);
        chk(dbgEnable_r, 32'h0);
        go(DRET, 3'h0, 8'h00, 32'h0, F0);
        st(base);
        chk(retPc_r, 32'h0000_0D06);
        go(DRET, 3'h0, 8'h00, 32'h0, F0);
        st(base);
        chk(retPcValid_r, 32'h0);
        // Trap set and clear, bytecode state, remap
        for (int i = 0; i < 6; i++) begin
            go(16'h0010 << i, 3'h0, 8'h00, 32'h0, F0);
            st(i % 2 ? base : base | tabB[i / 2]);
        end
        // Flags, sticky saturation and its clear
        go(16'h0000, 3'h0, 8'h00, 32'h0, 6'h37);
        st(base | 32'h0000_001B);
        go(16'h0000, 3'h0, 8'h00, 32'h0, 6'h28);
        st(base | 32'h0000_0014);
        go(SCLR, 3'h0, 8'h00, 32'h0, F0);
        st(base | 32'h0000_0004);
        // Lock set, then cleared by exception return
        go(LOCK | LVAL, 3'h0, 8'h00, 32'h0, F0);
        st(base | 32'h0000_0024);
        go(ENT, MODE_EXC, 8'h00, 32'h0, F0);
        go(RET | REXC, 3'h0, 8'h00, 32'h0, F0);
        st(base | 32'h0000_0004);
        go(WR, 3'h0, SR_IDX, base | 32'h0000_4000, F0);
        st(base | 32'h0000_4000);
        // Return into an application word built by software; a return
        // from application mode is then refused
        go(ENT, MODE_SUP, 8'h00, 32'h0, F0);
        go(WR, 3'h0, RSR_SUP_IDX, 32'h0000_0000, F0);
        go(RET, 3'h0, 8'h00, 32'h0, F0);
        st(32'h0000_0000);
        chk({shadowHigh_r, sysStack_r}, 32'h0);
        go(RET, 3'h0, 8'h00, 32'h0, F0);
        chk(retPcValid_r, 32'h0);
        st(32'h0000_0000);
        end_of_test();
    end
endmodule
